// ### adc_frame_defines.svh
`ifndef ADC_FRAME_DEFINES_SVH
`define ADC_FRAME_DEFINES_SVH
`define RES_BITS 8
`define CNT_W 6
`define LEAD_ZEROS 6'h02
`define DATA_END 6'h0A
`define CAL_PWRUP_EDGES 6'h10
`define CAL_RUN_START 6'h11
`define CAL_RUN_END 6'h20
`define ACQ_TIME_NS 275
`define CLK_PERIOD_NS 20
`define ACQ_CYCLES ((`ACQ_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACQ_CNT_W 5
`endif

// ### adc_frame_pkg.sv
package adc_frame_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_CONV = 4'h2,
        ST_HOLD = 4'h4,
        ST_CAL = 4'h8
    } frame_state_t;
endpackage

// ### sync2.sv
`timescale 1ns/1ps
module sync2 (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta_q;
    logic meta_d;
    logic sync_d;
    always_comb begin
        meta_d = d_i;
        sync_d = meta_q;
    end
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            meta_q <= 1'b1;
            q_o <= 1'b1;
        end else begin
            meta_q <= meta_d;
            q_o <= sync_d;
        end
    end
endmodule

// ### sar_adc_frame.sv
`timescale 1ns/1ps
`include "adc_frame_defines.svh"
// Function
// R1 - chip select fall captures differential input and starts conversion
// R2 - host serial clock steps conversion and shifts data, no oscillator
// R3 - inputs isolated during conversion, acquisition resumes afterwards
// R4 - host runs 12 MHz serial clock for full throughput; host_model takes 8 mclk cycles per clock, 6.25 MHz
// R5 - user offset calibration at power-up or later, applied to results
// R6 - results are unsigned straight-binary 8-bit codes
// R7 - frame ends on chip select rise, output released
// R8 - zero on cs fall, second zero, eight bits, low after ten clocks
// R9 - host allows 275 ns acquisition before next sample
// R10 - first frame calibrates, output low, needs 16 falling edges
// R11 - host clock 0.016 to 12 MHz, 45-55 percent duty, cs high 60 ns
module sar_adc_frame (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic [7:0] sample_code_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    output logic sample_hold_o,
    output logic input_isolate_o,
    output logic acq_ready_o,
    output logic [7:0] result_o,
    output logic [7:0] offset_correction_store_o,
    output logic result_valid_o
);
    import adc_frame_pkg::*;
    logic cs_s;
    logic sclk_s;
    frame_state_t state_q, state_d;
    logic cs_prev_q, cs_prev_d;
    logic sclk_prev_q, sclk_prev_d;
    logic [`CNT_W-1:0] edge_q, edge_d;
    logic [7:0] samp_q, samp_d;
    logic [7:0] shift_q, shift_d;
    logic powered_q, powered_d;
    logic [`ACQ_CNT_W-1:0] acq_q, acq_d;
    logic sdo_d, oe_d, hold_d, iso_d, acqr_d, valid_d;
    logic [7:0] res_d, ocr_d;
    logic cs_fall, cs_rise, sclk_fall;
    logic [8:0] diff;

    // cs and sclk pins leave the link domain through two flops before any logic
    sync2 cs_sync (.mclk_i(mclk_i), .reset_i(reset_i), .d_i(cs_n_i), .q_o(cs_s));
    sync2 ck_sync (.mclk_i(mclk_i), .reset_i(reset_i), .d_i(sclk_i), .q_o(sclk_s));

    always_comb begin
        cs_fall = cs_prev_q & ~cs_s;
        cs_rise = ~cs_prev_q & cs_s;
        sclk_fall = sclk_prev_q & ~sclk_s & ~cs_s; // R2
        // offset subtracted with floor at zero keeps code unsigned
        diff = {1'b0, samp_q} - {1'b0, offset_correction_store_o}; // R5 R6
        state_d = state_q;
        cs_prev_d = cs_s;
        sclk_prev_d = sclk_s;
        edge_d = edge_q;
        samp_d = samp_q;
        shift_d = shift_q;
        powered_d = powered_q;
        acq_d = acq_q;
        sdo_d = sdo_o;
        oe_d = sdo_oe_o;
        hold_d = sample_hold_o;
        iso_d = input_isolate_o;
        acqr_d = acq_ready_o;
        res_d = result_o;
        ocr_d = offset_correction_store_o;
        valid_d = 1'b0;
        if (acq_q != '0) begin
            acq_d = acq_q - 1'b1;
        end else if (!input_isolate_o) begin
            acqr_d = 1'b1;
        end
        if (cs_fall) begin
            edge_d = '0;
            oe_d = 1'b1;
            sdo_d = 1'b0; // R8
            acqr_d = 1'b0;
            hold_d = 1'b1;
            iso_d = 1'b1; // R3
            if (!powered_q) begin
                state_d = ST_CAL; // R10
            end else begin
                samp_d = sample_code_i; // R1
                state_d = ST_CONV;
            end
        end else if (cs_rise) begin
            oe_d = 1'b0; // R7
            sdo_d = 1'b0;
            if (state_q == ST_CAL) begin
                powered_d = 1'b1;
            end
            if (iso_d || state_q != ST_IDLE) begin
                iso_d = 1'b0;
                hold_d = 1'b0;
                acq_d = `ACQ_CNT_W'(`ACQ_CYCLES);
            end
            state_d = ST_IDLE;
        end else if (sclk_fall && edge_q != '1) begin
            edge_d = edge_q + 1'b1;
            case (state_q)
                ST_CONV: begin
                    if (edge_d == `LEAD_ZEROS - 6'h01) begin
                        shift_d = diff[8] ? 8'h00 : diff[7:0];
                        sdo_d = 1'b0;
                    end else if (edge_d <= `DATA_END) begin
                        sdo_d = shift_q[7]; // R8
                        shift_d = {shift_q[6:0], 1'b0};
                    end
                    if (edge_d == `DATA_END) begin
                        res_d = diff[8] ? 8'h00 : diff[7:0]; // R6
                        valid_d = 1'b1;
                        iso_d = 1'b0; // R3
                        hold_d = 1'b0;
                        acq_d = `ACQ_CNT_W'(`ACQ_CYCLES); // R9
                        state_d = ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    sdo_d = 1'b0; // R8
                    if (edge_d == `CAL_RUN_START) begin
                        iso_d = 1'b1;
                        // no acquisition can count while the inputs are cut off again
                        acqr_d = 1'b0; // R3
                    end
                    if (edge_d == `CAL_RUN_END) begin
                        ocr_d = sample_code_i; // R5
                        iso_d = 1'b0;
                        acq_d = `ACQ_CNT_W'(`ACQ_CYCLES);
                    end
                end
                ST_CAL: begin
                    sdo_d = 1'b0; // R10
                    if (edge_d == `CAL_PWRUP_EDGES) begin
                        ocr_d = sample_code_i; // R10
                        iso_d = 1'b0;
                        hold_d = 1'b0;
                        acq_d = `ACQ_CNT_W'(`ACQ_CYCLES);
                    end
                end
                default: begin
                    sdo_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_q <= ST_IDLE;
            cs_prev_q <= 1'b1;
            sclk_prev_q <= 1'b0;
            edge_q <= '0;
            samp_q <= 8'h00;
            shift_q <= 8'h00;
            powered_q <= 1'b0;
            acq_q <= '0;
            sdo_o <= 1'b0;
            sdo_oe_o <= 1'b0;
            sample_hold_o <= 1'b0;
            input_isolate_o <= 1'b0;
            acq_ready_o <= 1'b0;
            result_o <= 8'h00;
            offset_correction_store_o <= 8'h00;
            result_valid_o <= 1'b0;
        end else begin
            state_q <= state_d;
            cs_prev_q <= cs_prev_d;
            sclk_prev_q <= sclk_prev_d;
            edge_q <= edge_d;
            samp_q <= samp_d;
            shift_q <= shift_d;
            powered_q <= powered_d;
            acq_q <= acq_d;
            sdo_o <= sdo_d;
            sdo_oe_o <= oe_d;
            sample_hold_o <= hold_d;
            input_isolate_o <= iso_d;
            acq_ready_o <= acqr_d;
            result_o <= res_d;
            offset_correction_store_o <= ocr_d;
            result_valid_o <= valid_d;
        end
    end

    cs_fall_drives_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        cs_fall |=> sdo_oe_o && !sdo_o && input_isolate_o) // R8
        else $error("output not driven low after cs fall");
    cs_rise_release_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        cs_rise |=> !sdo_oe_o) // R7
        else $error("output not released after cs rise");
    cal_frame_low_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        state_q == ST_CAL |-> !sdo_o) // R10
        else $error("output high during calibration frame");
    first_frame_cal_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        cs_fall && !powered_q |=> state_q == ST_CAL) // R10
        else $error("first frame did not calibrate");
    tail_low_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        state_q == ST_HOLD && $past(state_q) == ST_HOLD |-> !sdo_o) // R8
        else $error("output not low after ten clocks");
    sample_capture_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        cs_fall && powered_q |=> samp_q == $past(sample_code_i)) // R1
        else $error("sample not captured on cs fall");
    conv_end_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        result_valid_o |-> !input_isolate_o ##1 acq_q != '0) // R3
        else $error("inputs not reconnected after conversion");
    acq_wait_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        $fell(input_isolate_o) && !cs_fall |-> !acq_ready_o [*2]) // R9
        else $error("acquisition ready too early");
    hold_isolated_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R3
        sample_hold_o |-> input_isolate_o)
        else $error("sample held while inputs connected");
    ready_isolated_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R3
        acq_ready_o |-> !input_isolate_o)
        else $error("acquisition ready while inputs isolated");
    conv_c: cover property (@(posedge mclk_i) disable iff (reset_i) result_valid_o);
    cal_c: cover property (@(posedge mclk_i) disable iff (reset_i) $changed(offset_correction_store_o));
    run_cal_c: cover property (@(posedge mclk_i) disable iff (reset_i)
        state_q == ST_HOLD && edge_q == `CAL_RUN_END);
    pwrup_cal_c: cover property (@(posedge mclk_i) disable iff (reset_i)
        state_q == ST_CAL && edge_q == `CAL_PWRUP_EDGES);
endmodule

// ### host_model.sv
`timescale 1ns/1ps
module host_model (
    input wire logic mclk_i,
    input wire logic sdo_i,
    input wire logic sdo_oe_i,
    output logic cs_n_o,
    output logic sclk_o
);
    logic [40:0] rx_bits;
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0; // stands still between frames
        rx_bits = '0;
    end
    task automatic half();
        repeat (4) @(posedge mclk_i);
        #1;
    endtask
    // a released line reads as unknown so it can never pass as a zero
    task automatic frame(input int nclk);
        rx_bits = '0;
        half();
        cs_n_o = 1'b0;
        for (int k = 0; k < nclk; k++) begin
            half();
            sclk_o = 1'b1;
            half();
            rx_bits[k] = sdo_oe_i ? sdo_i : 1'bx;
            sclk_o = 1'b0;
        end
        half();
        half();
        rx_bits[nclk] = sdo_oe_i ? sdo_i : 1'bx;
        cs_n_o = 1'b1;
        repeat (4) half();
    endtask
endmodule

// ### sar_adc_serial_conversion_frame_bench.sv
`timescale 1ns/1ps
module sar_adc_serial_conversion_frame_bench;
    logic mclk_i, reset_i, cs_n, sclk, sdo, sdo_oe, hold, iso, acq, valid;
    logic [7:0] code, result, store, offset;
    logic [7:0] exp_q[$];
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end
    sar_adc_frame sar_adc_frame_inst (.mclk_i(mclk_i), .reset_i(reset_i), .cs_n_i(cs_n),
        .sclk_i(sclk), .sample_code_i(code), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
        .sample_hold_o(hold), .input_isolate_o(iso), .acq_ready_o(acq), .result_o(result),
        .offset_correction_store_o(store), .result_valid_o(valid));
    host_model host_model_inst (.mclk_i(mclk_i), .sdo_i(sdo), .sdo_oe_i(sdo_oe),
        .cs_n_o(cs_n), .sclk_o(sclk));
    task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic do_reset();
        reset_i = 1'b1;
        repeat (5) @(posedge mclk_i);
        #1 reset_i = 1'b0;
        offset = 8'h00;
    endtask
    // cal marks the first frame after power-up, whose output stays low
    task automatic run(input int n, input bit cal);
        logic [7:0] exp;
        logic want;
        exp = (code > offset) ? code - offset : 8'h00;
        // well past the acquisition interval since the last frame, so ready must show
        repeat (4) @(posedge mclk_i);
        #1;
        check("acq ready", 10'h001, acq);
        if (!cal)
            exp_q.push_back(exp);
        host_model_inst.frame(n);
        for (int k = 0; k <= n; k++) begin
            want = (!cal && k >= 2 && k <= 9) ? exp[9 - k] : 1'b0;
            check("sdo bit", 10'(want), 10'(host_model_inst.rx_bits[k]));
        end
        check("sdo enable", 10'h000, sdo_oe);
        check("isolate", 10'h000, iso);
        check("hold", 10'h000, hold);
    endtask
    // looked at mid-cycle so the one-cycle pulse is settled; a pulse without a note is a fault
    always @(negedge mclk_i) begin
        if (valid === 1'b1) begin
            check("result note", 10'h001, 10'(exp_q.size() != 0));
            if (exp_q.size() != 0)
                check("result", exp_q.pop_front(), result);
        end
    end
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 8000) begin
            failures++;
            give_verdict();
        end
    end
    initial begin
        reset_i = 1'b1;
        code = 8'($urandom(32'hD5A3));
        do_reset();
        code = 8'h07;
        run(8, 1'b1);
        check("store", 10'h000, store);
        code = 8'($urandom);
        run(10, 1'b0);
        do_reset();
        code = 8'h05 + 8'($urandom % 8);
        run(16, 1'b1);
        offset = code;
        check("store", {2'b00, offset}, store);
        for (int i = 0; i < 6; i++) begin
            code = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
            run(10, 1'b0);
        end
        code = 8'h20 + 8'($urandom % 16);
        run(32, 1'b0);
        offset = code;
        check("store", {2'b00, offset}, store);
        code = 8'($urandom);
        run(10, 1'b0);
        repeat (4) @(posedge mclk_i);
        check("pending results", 10'h000, 10'(exp_q.size()));
        give_verdict();
    end
endmodule
